// ==== inc/afr_pkg.sv ====
// Shared constants and types of the API frame engine
package afr_pkg;
	// Frame framing and type codes
	localparam logic [7:0]  START_DELIM   = 8'h7E;
	localparam logic [7:0]  T_RX64        = 8'h80;
	localparam logic [7:0]  T_LCL_REQ     = 8'h08;
	localparam logic [7:0]  T_LCL_QREQ    = 8'h09;
	localparam logic [7:0]  T_LCL_RSP     = 8'h88;
	localparam logic [7:0]  T_REM_REQ     = 8'h17;
	localparam logic [7:0]  T_REM_RSP     = 8'h97;
	localparam logic [7:0]  CSUM_GOOD     = 8'hFF;
	// Receive gating
	localparam logic [7:0]  OUT_LEGACY    = 8'h02;
	localparam logic [15:0] SHORT_NONE    = 16'hFFFE;
	// Byte offsets shared by all frames; receive frames carry the address, not the identifier, at offset 4
	localparam logic [8:0]  OFS_LENH      = 9'h001;
	localparam logic [8:0]  OFS_LENL      = 9'h002;
	localparam logic [8:0]  OFS_TYPE      = 9'h003;
	localparam logic [8:0]  OFS_ID        = 9'h004;
	// Receive frame offsets
	localparam logic [8:0]  OFS_RXADDR    = 9'h004;
	localparam logic [8:0]  OFS_RSSI      = 9'h00C;
	localparam logic [8:0]  OFS_RXOPT     = 9'h00D;
	localparam logic [8:0]  OFS_PAYLOAD   = 9'h00E;
	// Local request and response offsets
	localparam logic [15:0] OFS_LCMD      = 16'h0005;
	localparam logic [15:0] OFS_LVAL      = 16'h0007;
	localparam logic [8:0]  OFS_LSTAT     = 9'h007;
	localparam logic [8:0]  OFS_LDATA     = 9'h008;
	// Remote request offsets
	localparam logic [15:0] OFS_RADDR     = 16'h0005;
	localparam logic [15:0] OFS_ROPT      = 16'h000F;
	localparam logic [15:0] OFS_RCMD      = 16'h0010;
	localparam logic [15:0] OFS_RVAL      = 16'h0012;
	// Remote response offsets
	localparam logic [8:0]  OFS_QADDR     = 9'h005;
	localparam logic [8:0]  OFS_QRSV      = 9'h00D;
	localparam logic [8:0]  OFS_QCMD      = 9'h00F;
	localparam logic [8:0]  OFS_QSTAT     = 9'h011;
	localparam logic [8:0]  OFS_QDATA     = 9'h012;
	// Fixed body lengths, payload excluded
	localparam logic [15:0] LEN_RX_FIX    = 16'h000B;
	localparam logic [15:0] LEN_LCL_FIX   = 16'h0005;
	localparam logic [15:0] LEN_REM_FIX   = 16'h000F;
	// Receive option bit positions
	localparam int          RXO_BCAST     = 1;
	localparam int          RXO_ALLPAN    = 2;
	// Command status codes
	localparam logic [7:0]  ST_OK         = 8'h00;
	localparam logic [7:0]  ST_ERROR      = 8'h01;
	localparam logic [7:0]  ST_BAD_CMD    = 8'h02;
	localparam logic [7:0]  ST_BAD_PARAM  = 8'h03;
	// Frame kinds
	typedef enum logic [1:0] {K_RX = 2'h0, K_LCL = 2'h1, K_REM = 2'h2}
		afr_kind_e;
endpackage

// ==== rtl/afr_csum.sv ====
// Running eight-bit frame sum
`timescale 1ns/10ps
module afr_csum (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Control and data
	input  wire logic       clr,
	input  wire logic       add,
	input  wire logic [7:0] data,
	// Sum of added bytes
	output logic      [7:0] sum
);
	// Carry out of bit 7 is dropped on purpose
	always_ff @(posedge clk) begin
		if (rst || clr) begin
			sum <= 8'h00;
		end else if (add) begin
			sum <= 8'(sum + data);
		end
	end
endmodule // afr_csum

// ==== rtl/afr_frame_engine.sv ====
// API frame request checker and response builder
`timescale 1ns/10ps
// What this block does
// - Receive frame only in legacy mode, long sender
// - Delimiter then 16-bit body length
// - Type, address, signal, options, payload offsets
// - Signal byte is negative dBm magnitude
// - Options: bit1 broadcast, bit2 all networks
// - Checksum is FF minus body sum
// - Local requests get 0x88 responses, maybe several
// - Zero frame identifier suppresses the response
// - Remote request answered by 0x97, same identifier
// - Status: ok, error, bad command, bad parameter
module afr_frame_engine import afr_pkg::*; (
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        SYS_RST,
	// Configuration
	input  wire logic [7:0]  API_OUTPUT_OPTION,
	// Host request byte stream
	input  wire logic [7:0]  HOST_BYTE,
	input  wire logic        HOST_BYTE_VALID,
	// Decoded request
	output logic             REQ_VALID,
	output logic             REQ_QUEUED,
	output logic             REQ_REMOTE,
	output logic [7:0]       REQ_FRAME_ID,
	output logic [15:0]      REQ_CMD,
	output logic [63:0]      REQ_ADDR,
	output logic [7:0]       REQ_OPTIONS,
	output logic [15:0]      REQ_VALUE,
	output logic [7:0]       REQ_VALUE_LEN,
	output logic             CSUM_ERR,
	// Command results
	input  wire logic        RSP_VALID,
	input  wire logic [7:0]  RSP_STATUS,
	input  wire logic [15:0] RSP_DATA,
	input  wire logic [1:0]  RSP_DATA_LEN,
	output logic             RSP_READY,
	// Radio receive side
	input  wire logic        RF_PKT_VALID,
	input  wire logic [63:0] RF_SRC_ADDR,
	input  wire logic [15:0] RF_SRC_SHORT,
	input  wire logic [7:0]  RF_DBM_MAG,
	input  wire logic        RF_BCAST,
	input  wire logic        RF_BCAST_ALL_PAN,
	input  wire logic [7:0]  RF_LEN,
	input  wire logic [7:0]  RF_PAYLOAD_BYTE,
	output logic             RF_PKT_TAKE,
	output logic [7:0]       RF_PAYLOAD_IDX,
	// Host response byte stream
	output logic [7:0]       TX_BYTE,
	output logic             TX_VALID,
	input  wire logic        TX_READY
);
	typedef enum logic [4:0] {P_HUNT = 5'h01, P_LENH = 5'h02, P_LENL = 5'h04,
		P_BODY = 5'h08, P_CSUM = 5'h10} afr_pst_e;
	typedef enum logic [1:0] {E_IDLE = 2'h1, E_SEND = 2'h2} afr_est_e;

	afr_pst_e    p_state;
	logic [15:0] p_len;
	logic [15:0] p_idx;
	logic [7:0]  p_type;
	logic [7:0]  p_id;
	logic [15:0] p_cmd;
	logic [7:0]  p_opt;
	logic [63:0] p_addr;
	logic [15:0] p_val;
	logic [7:0]  p_vlen;
	logic [7:0]  p_sum;
	logic        p_good;
	logic        p_known;
	logic        p_isval;

	// Request checksum and type screening
	assign p_good  = 8'(p_sum + HOST_BYTE) == CSUM_GOOD;
	assign p_known = p_type == T_LCL_REQ || p_type == T_LCL_QREQ
		|| p_type == T_REM_REQ;
	assign p_isval = p_type == T_REM_REQ ? p_idx >= OFS_RVAL
		: p_idx >= OFS_LVAL;

	afr_csum u_rx_sum (
		.clk  (CLK_SYS),
		.rst  (SYS_RST),
		.clr  (p_state == P_HUNT),
		.add  (HOST_BYTE_VALID && p_state == P_BODY),
		.data (HOST_BYTE),
		.sum  (p_sum)
	);

	// Request parser; only a delimiter leaves the hunt state
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			p_state <= P_HUNT;
			p_len   <= 16'h0000;
			p_idx   <= 16'h0000;
		end else if (HOST_BYTE_VALID) begin
			case (p_state)
				P_HUNT: if (HOST_BYTE == START_DELIM) p_state <= P_LENH;
				P_LENH: begin
					p_len[15:8] <= HOST_BYTE;
					p_state     <= P_LENL;
				end
				P_LENL: begin
					p_len[7:0] <= HOST_BYTE;
					p_idx      <= 16'(OFS_TYPE);
					p_state    <= {p_len[15:8], HOST_BYTE} == 16'h0000 ?
						P_CSUM : P_BODY;
				end
				P_BODY: begin
					p_idx <= p_idx + 16'h0001;
					if (p_idx == p_len + 16'(OFS_LENL)) p_state <= P_CSUM;
				end
				P_CSUM: p_state <= P_HUNT;
				default: p_state <= P_HUNT;
			endcase
		end
	end

	// Field capture inside the body
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			p_type <= 8'h00;
			p_id   <= 8'h00;
			p_cmd  <= 16'h0000;
			p_opt  <= 8'h00;
			p_addr <= 64'h0;
			p_val  <= 16'h0000;
			p_vlen <= 8'h00;
		end else if (HOST_BYTE_VALID && p_state == P_LENL) begin
			p_vlen <= 8'h00;
			p_val  <= 16'h0000;
			p_type <= 8'h00;
		end else if (HOST_BYTE_VALID && p_state == P_BODY) begin
			if (p_idx == 16'(OFS_TYPE)) p_type <= HOST_BYTE;
			if (p_idx == 16'(OFS_ID)) p_id <= HOST_BYTE;
			if (p_type == T_REM_REQ && p_idx >= OFS_RADDR && p_idx < OFS_ROPT - 2)
				p_addr <= {p_addr[55:0], HOST_BYTE};
			// Apply, queue, no-ack and secure bits pass to the core
			if (p_type == T_REM_REQ && p_idx == OFS_ROPT)
				p_opt <= HOST_BYTE;
			if ((p_type == T_REM_REQ && (p_idx == OFS_RCMD
				|| p_idx == OFS_RCMD + 1)) || (p_type != T_REM_REQ
				&& (p_idx == OFS_LCMD || p_idx == OFS_LCMD + 1)))
				p_cmd <= {p_cmd[7:0], HOST_BYTE};
			// No value bytes means a query
			if (p_isval) begin
				p_val  <= {p_val[7:0], HOST_BYTE};
				p_vlen <= p_vlen == 8'hFF ? p_vlen : p_vlen + 8'h01;
			end
		end
	end

	// Publish a request only after its checksum verifies
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			REQ_VALID     <= 1'b0;
			CSUM_ERR      <= 1'b0;
			REQ_QUEUED    <= 1'b0;
			REQ_REMOTE    <= 1'b0;
			REQ_FRAME_ID  <= 8'h00;
			REQ_CMD       <= 16'h0000;
			REQ_ADDR      <= 64'h0;
			REQ_OPTIONS   <= 8'h00;
			REQ_VALUE     <= 16'h0000;
			REQ_VALUE_LEN <= 8'h00;
		end else begin
			REQ_VALID <= HOST_BYTE_VALID && p_state == P_CSUM && p_good
				&& p_known;
			CSUM_ERR  <= HOST_BYTE_VALID && p_state == P_CSUM && !p_good;
			if (HOST_BYTE_VALID && p_state == P_CSUM && p_good && p_known) begin
				REQ_QUEUED    <= p_type == T_LCL_QREQ;
				REQ_REMOTE    <= p_type == T_REM_REQ;
				REQ_FRAME_ID  <= p_id;
				REQ_CMD       <= p_cmd;
				REQ_ADDR      <= p_type == T_REM_REQ ? p_addr : 64'h0;
				REQ_OPTIONS   <= p_type == T_REM_REQ ? p_opt : 8'h00;
				REQ_VALUE     <= p_val;
				REQ_VALUE_LEN <= p_vlen;
			end
		end
	end

	afr_est_e    e_state;
	afr_est_e    e_state_next;
	afr_kind_e   e_kind;
	logic [8:0]  pos_reg;
	logic [8:0]  pos_next;
	logic [7:0]  e_id;
	logic [15:0] e_cmd;
	logic [63:0] e_addr;
	logic [7:0]  e_status;
	logic [15:0] e_data;
	logic [1:0]  e_dlen;
	logic [7:0]  e_rssi;
	logic [7:0]  e_opts;
	logic [7:0]  e_plen;
	logic [15:0] body_len;
	logic [8:0]  last_pos;
	logic [7:0]  tx_next;
	logic [7:0]  e_sum;
	logic        load;
	logic        rsp_go;
	logic        rx_go;
	logic        rx_ok;

	// Start and pacing terms; responses win over receive frames
	assign load   = !TX_VALID || TX_READY;
	assign rsp_go = RSP_READY && RSP_VALID;
	assign rx_go  = RSP_READY && !RSP_VALID && RF_PKT_VALID && !RF_PKT_TAKE;
	assign rx_ok  = API_OUTPUT_OPTION == OUT_LEGACY
		&& RF_SRC_SHORT == SHORT_NONE;
	assign body_len = e_kind == K_RX ? LEN_RX_FIX + 16'(e_plen)
		: (e_kind == K_LCL ? LEN_LCL_FIX : LEN_REM_FIX) + 16'(e_dlen);
	assign last_pos = 9'(body_len) + OFS_TYPE;

	function automatic logic [7:0] abyte(input logic [63:0] a,
		input logic [8:0] k);
		abyte = a[8 * (7 - int'(k[2:0])) +: 8];
	endfunction

	function automatic logic [7:0] dbyte(input logic [8:0] k);
		dbyte = (k == 9'h000 && e_dlen == 2'h2) ? e_data[15:8] : e_data[7:0];
	endfunction

	// Next byte of the outgoing frame by position
	always_comb begin
		tx_next = 8'h00;
		if (pos_reg == 9'h000) tx_next = START_DELIM;
		else if (pos_reg == OFS_LENH) tx_next = body_len[15:8];
		else if (pos_reg == OFS_LENL) tx_next = body_len[7:0];
		else if (pos_reg == last_pos) tx_next = CSUM_GOOD - e_sum;
		else if (pos_reg == OFS_TYPE) tx_next = e_kind == K_RX ? T_RX64
			: (e_kind == K_LCL ? T_LCL_RSP : T_REM_RSP);
		else if (e_kind == K_RX) begin
			if (pos_reg < OFS_RSSI) tx_next = abyte(e_addr, pos_reg - OFS_RXADDR);
			else if (pos_reg == OFS_RSSI) tx_next = e_rssi;
			else if (pos_reg == OFS_RXOPT) tx_next = e_opts;
			else tx_next = RF_PAYLOAD_BYTE;
		end else if (pos_reg == OFS_ID) tx_next = e_id;
		else if (e_kind == K_LCL) begin
			if (pos_reg < OFS_LSTAT) tx_next = pos_reg == OFS_LSTAT - 2 ?
				e_cmd[15:8] : e_cmd[7:0];
			else if (pos_reg == OFS_LSTAT) tx_next = e_status;
			else tx_next = dbyte(pos_reg - OFS_LDATA);
		end else begin
			if (pos_reg < OFS_QRSV) tx_next = abyte(e_addr, pos_reg - OFS_QADDR);
			else if (pos_reg < OFS_QCMD) tx_next = pos_reg == OFS_QRSV ?
				SHORT_NONE[15:8] : SHORT_NONE[7:0];
			else if (pos_reg < OFS_QSTAT) tx_next = pos_reg == OFS_QCMD ?
				e_cmd[15:8] : e_cmd[7:0];
			else if (pos_reg == OFS_QSTAT) tx_next = e_status;
			else tx_next = dbyte(pos_reg - OFS_QDATA);
		end
	end

	// Emitter sequencing; a zero identifier never starts a frame
	always_comb begin
		e_state_next = e_state;
		pos_next     = pos_reg;
		case (e_state)
			E_IDLE: if ((rsp_go && REQ_FRAME_ID != 8'h00)
				|| (rx_go && rx_ok)) begin
				e_state_next = E_SEND;
				pos_next     = 9'h000;
			end
			E_SEND: if (load) begin
				pos_next = pos_reg + 9'h001;
				if (pos_reg == last_pos) e_state_next = E_IDLE;
			end
			default: e_state_next = E_IDLE;
		endcase
	end

	afr_csum u_tx_sum (
		.clk  (CLK_SYS),
		.rst  (SYS_RST),
		.clr  (e_state == E_IDLE),
		.add  (e_state == E_SEND && load && pos_reg >= OFS_TYPE
			&& pos_reg != last_pos),
		.data (tx_next),
		.sum  (e_sum)
	);

	// State, position and handshake flops
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			e_state        <= E_IDLE;
			pos_reg        <= 9'h000;
			RF_PAYLOAD_IDX <= 8'h00;
			RSP_READY      <= 1'b0;
			RF_PKT_TAKE    <= 1'b0;
		end else begin
			e_state        <= e_state_next;
			pos_reg        <= pos_next;
			RF_PAYLOAD_IDX <= 8'(pos_next - OFS_PAYLOAD);
			RSP_READY      <= e_state_next == E_IDLE;
			RF_PKT_TAKE    <= rx_go; // Unqualified packets are taken and dropped
		end
	end

	// Latch frame contents at start; several answers may follow one request
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			e_kind   <= K_RX;
			e_id     <= 8'h00;
			e_cmd    <= 16'h0000;
			e_addr   <= 64'h0;
			e_status <= ST_OK;
			e_data   <= 16'h0000;
			e_dlen   <= 2'h0;
			e_rssi   <= 8'h00;
			e_opts   <= 8'h00;
			e_plen   <= 8'h00;
		end else if (rsp_go) begin
			e_kind   <= REQ_REMOTE ? K_REM : K_LCL;
			e_id     <= REQ_FRAME_ID;
			e_cmd    <= REQ_CMD;
			e_addr   <= REQ_ADDR;
			e_status <= RSP_STATUS;
			e_data   <= RSP_DATA;
			e_dlen   <= RSP_DATA_LEN > 2'h2 ? 2'h2 : RSP_DATA_LEN;
		end else if (rx_go) begin
			e_kind <= K_RX;
			e_addr <= RF_SRC_ADDR;
			e_rssi <= RF_DBM_MAG;
			e_opts <= {5'h00, RF_BCAST_ALL_PAN, RF_BCAST, 1'b0};
			e_plen <= RF_LEN;
		end
	end

	// Output byte register, held while the host stalls
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			TX_BYTE  <= 8'h00;
			TX_VALID <= 1'b0;
		end else if (load) begin
			TX_BYTE  <= e_state == E_SEND ? tx_next : TX_BYTE;
			TX_VALID <= e_state == E_SEND;
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);

	sequence s_emit(logic [8:0] p);
		e_state == E_SEND && load && pos_reg == p;
	endsequence
	sequence s_start;
		e_state == E_IDLE ##1 e_state == E_SEND;
	endsequence

	property p_rx_gate;
		s_start ##0 e_kind == K_RX |-> $past(rx_ok);
	endproperty
	a_rx_gate: assert property (p_rx_gate)
		else $error("rx frame not gated");

	property p_delim;
		s_emit(9'h000) |=> TX_VALID && TX_BYTE == START_DELIM ##0
			e_state == E_SEND;
	endproperty
	a_delim: assert property (p_delim)
		else $error("bad delimiter");

	// A stalled host may hold the signal byte, so only the next slot is named
	property p_rx_layout;
		s_emit(OFS_RSSI) ##0 e_kind == K_RX |=> TX_BYTE == e_rssi
			&& pos_reg == OFS_RXOPT;
	endproperty
	a_rx_layout: assert property (p_rx_layout)
		else $error("rx layout");

	property p_rssi;
		rx_go && rx_ok |=> e_rssi == $past(RF_DBM_MAG);
	endproperty
	a_rssi: assert property (p_rssi)
		else $error("rssi byte wrong");

	property p_opt_rsvd;
		s_emit(OFS_RXOPT) ##0 e_kind == K_RX |=> TX_BYTE == e_opts
			&& TX_BYTE[0] == 1'b0;
	endproperty
	a_opt_rsvd: assert property (p_opt_rsvd)
		else $error("rx option bit0");

	// Idle right after the sum; a new frame may start one cycle later
	property p_csum;
		e_state == E_SEND && load && pos_reg == last_pos
			|=> 8'(TX_BYTE + $past(e_sum)) == CSUM_GOOD && e_state == E_IDLE;
	endproperty
	a_csum: assert property (p_csum)
		else $error("checksum wrong");

	property p_zero_id;
		rsp_go && REQ_FRAME_ID == 8'h00 |=> e_state == E_IDLE [*2];
	endproperty
	a_zero_id: assert property (p_zero_id)
		else $error("zero id answered");

	property p_same_id;
		s_emit(OFS_ID) ##0 e_kind != K_RX |=> TX_BYTE == e_id;
	endproperty
	a_same_id: assert property (p_same_id)
		else $error("frame id differs");

	property p_status;
		s_emit(OFS_LSTAT) ##0 e_kind == K_LCL |=> TX_BYTE == e_status;
	endproperty
	a_status: assert property (p_status)
		else $error("status misplaced");

	property p_bad_drop;
		HOST_BYTE_VALID && p_state == P_CSUM && !p_good
			|=> CSUM_ERR && !REQ_VALID && p_state == P_HUNT;
	endproperty
	a_bad_drop: assert property (p_bad_drop)
		else $error("bad frame kept");
endmodule // afr_frame_engine

// ==== tb/afr_host_model.sv ====
// Host processor model on the serial side of the frame engine
`timescale 1ns/10ps
module afr_host_model (
	// Clock
	input  wire logic       clk,
	// Request stream into the device
	output logic      [7:0] host_byte,
	output logic            host_valid,
	// Response stream from the device
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	// Stall every other cycle when high
	input  wire logic       slow
);
	logic [7:0] rx_q[$];
	logic       ph;

	initial begin
		host_byte = 8'h00;
		host_valid = 1'b0;
		tx_ready = 1'b1;
		ph = 1'b0;
	end

	// Collect every byte the device hands over
	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			rx_q.push_back(tx_byte);
	end

	// A slow host refuses half of the cycles
	always @(negedge clk) begin
		ph = ~ph;
		tx_ready = !slow || ph;
	end

	// Delimiter, length, body, checksum; bad flips the checksum's low bit
	task automatic send(input logic [7:0] body[$], input logic bad);
		logic [7:0] fr[$];
		logic [7:0] s;
		s = 8'h00;
		foreach (body[i]) s += body[i];
		fr = {8'h7E, 8'h00, 8'(body.size()), body};
		fr.push_back((8'hFF - s) ^ {7'h00, bad});
		foreach (fr[i]) begin
			@(negedge clk);
			host_byte = fr[i];
			host_valid = 1'b1;
		end
		@(negedge clk);
		host_valid = 1'b0;
		// Released line no longer shows the last byte
		host_byte = ~host_byte;
	endtask
endmodule // afr_host_model

// ==== tb/afr_frame_engine_tb.sv ====
// Self-checking bench of the API frame engine
`timescale 1ns/10ps
module afr_frame_engine_tb import afr_pkg::*;;
	typedef logic [7:0] afr_bytes_t[$];
	typedef struct {
		logic [7:0]  typ, id, opt;
		logic [15:0] cmd;
		int          vlen;
		logic [47:0] vb;
	} afr_row_s;
	localparam logic [63:0] DEST = 64'h1122334455667788; // Arbitrary value
	// Requests of every kind; host options apply, queue, no-ack plus secure
	afr_row_s rows[6] = '{
		'{8'h08, 8'h52, 8'h00, 16'h5450, 0, 48'h0},
		'{8'h09, 8'h33, 8'h00, 16'h4E49, 2, 48'h4142},
		'{8'h17, 8'h27, 8'h02, 16'h4E49, 6, 48'h52656D6F7465},
		'{8'h17, 8'h68, 8'h00, 16'h4944, 2, 48'h0451},
		'{8'h17, 8'hFA, 8'h00, 16'h5450, 0, 48'h0},
		'{8'h17, 8'h44, 8'h11, 16'h4E49, 2, 48'h0A0B}};
	logic        clk_sys = 1'b0, sys_rst = 1'b1, slow = 1'b0;
	logic [7:0]  out_opt = OUT_LEGACY, host_byte, req_id, req_opt, req_vlen;
	logic        host_valid, req_valid, req_queued, req_remote, csum_err;
	logic [15:0] req_cmd, req_val, rsp_data = 16'hFFFE;
	logic [63:0] req_addr, rf_addr = 64'h8877665544332211; // Arbitrary value
	logic        rsp_valid = 1'b0, rsp_ready, rf_valid = 1'b0, rf_take;
	logic [7:0]  rsp_status = 8'h00, rf_dbm = 8'h28, rf_len = 8'h01;
	logic [1:0]  rsp_dlen = 2'h0;
	logic [15:0] rf_short = 16'hFFFE;
	logic        rf_bc = 1'b0, rf_all = 1'b0, tx_valid, tx_ready;
	logic [7:0]  rf_pb, rf_idx, tx_byte;
	int          num_errors = 0, total_checks = 0, i;
	afr_row_s    r;
	afr_bytes_t  b;

	afr_frame_engine dut_u (.CLK_SYS(clk_sys), .SYS_RST(sys_rst),
		.API_OUTPUT_OPTION(out_opt), .HOST_BYTE(host_byte),
		.HOST_BYTE_VALID(host_valid), .REQ_VALID(req_valid),
		.REQ_QUEUED(req_queued), .REQ_REMOTE(req_remote),
		.REQ_FRAME_ID(req_id), .REQ_CMD(req_cmd), .REQ_ADDR(req_addr),
		.REQ_OPTIONS(req_opt), .REQ_VALUE(req_val),
		.REQ_VALUE_LEN(req_vlen), .CSUM_ERR(csum_err),
		.RSP_VALID(rsp_valid), .RSP_STATUS(rsp_status),
		.RSP_DATA(rsp_data), .RSP_DATA_LEN(rsp_dlen),
		.RSP_READY(rsp_ready), .RF_PKT_VALID(rf_valid),
		.RF_SRC_ADDR(rf_addr), .RF_SRC_SHORT(rf_short),
		.RF_DBM_MAG(rf_dbm), .RF_BCAST(rf_bc), .RF_BCAST_ALL_PAN(rf_all),
		.RF_LEN(rf_len), .RF_PAYLOAD_BYTE(rf_pb), .RF_PKT_TAKE(rf_take),
		.RF_PAYLOAD_IDX(rf_idx), .TX_BYTE(tx_byte), .TX_VALID(tx_valid),
		.TX_READY(tx_ready));
	afr_host_model host_u (.clk(clk_sys), .host_byte(host_byte),
		.host_valid(host_valid), .tx_byte(tx_byte), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .slow(slow));

	// Payload memory answers the index at once
	assign rf_pb = 8'hA0 + rf_idx;
	always #12.5 clk_sys = ~clk_sys;

	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Destination then the unused short address
	function automatic void add_addr(ref afr_bytes_t q);
		for (int j = 7; j >= 0; j--)
			q.push_back(DEST[8*j+:8]);
		q.push_back(8'hFF);
		q.push_back(8'hFE);
	endfunction

	function automatic afr_bytes_t mk_req(input afr_row_s x);
		afr_bytes_t q;
		q = {x.typ, x.id};
		if (x.typ == T_REM_REQ) begin
			add_addr(q);
			q.push_back(x.opt);
		end
		q.push_back(x.cmd[15:8]);
		q.push_back(x.cmd[7:0]);
		// Query leaves the value out entirely
		for (int j = x.vlen - 1; j >= 0; j--)
			q.push_back(x.vb[8*j+:8]);
		return q;
	endfunction

	function automatic afr_bytes_t rsp_body(input afr_row_s x,
		input logic [7:0] st, input logic [1:0] dl);
		afr_bytes_t q;
		q = {(x.typ == T_REM_REQ) ? T_REM_RSP : T_LCL_RSP, x.id};
		if (x.typ == T_REM_REQ)
			add_addr(q);
		q.push_back(x.cmd[15:8]);
		q.push_back(x.cmd[7:0]);
		q.push_back(st);
		// Two bytes go high first; one byte is the low half; three sends two
		if (dl > 2'h1)
			q.push_back(rsp_data[15:8]);
		if (dl != 2'h0)
			q.push_back(rsp_data[7:0]);
		return q;
	endfunction

	// Wrap the body, wait for the whole frame, compare every byte
	task automatic expect_frame(input afr_bytes_t q);
		logic [7:0] s;
		int         n;
		s = 8'h00;
		foreach (q[j]) s += q[j];
		q = {8'h7E, 8'h00, 8'(q.size()), q, 8'hFF - s};
		n = 0;
		while (host_u.rx_q.size() < q.size() && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		foreach (q[j]) chk("tx_byte", q[j], host_u.rx_q[j]);
		chk("frame_len", q.size(), host_u.rx_q.size());
		host_u.rx_q.delete();
	endtask

	// Result level held until the engine is ready at a sampling edge
	task automatic send_rsp(input logic [7:0] st, input logic [1:0] dl);
		int n;
		@(negedge clk_sys);
		rsp_status = st;
		rsp_dlen = dl;
		rsp_valid = 1'b1;
		n = 0;
		while (rsp_ready !== 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		@(negedge clk_sys);
		rsp_valid = 1'b0;
	endtask

	task automatic wait_req();
		for (int j = 0; j < 6 && req_valid !== 1'b1 && csum_err !== 1'b1; j++)
			@(negedge clk_sys);
	endtask

	task automatic chk_req(input afr_row_s x);
		logic rem;
		rem = x.typ == T_REM_REQ;
		chk("req_valid", 1'b1, req_valid);
		chk("req_id", x.id, req_id);
		chk("req_cmd", x.cmd, req_cmd);
		chk("req_queued", x.typ == T_LCL_QREQ, req_queued);
		chk("req_remote", rem, req_remote);
		chk("req_addr", rem ? DEST : 64'h0, req_addr);
		chk("req_opt", rem ? x.opt : 8'h00, req_opt);
		chk("req_vlen", x.vlen, req_vlen);
		if (x.vlen > 1)
			chk("req_val", x.vb[15:0], req_val);
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		finish_test();
	end

	initial begin
		repeat (8) @(negedge clk_sys);
		chk("rsp_ready", 1'b0, rsp_ready);
		chk("tx_valid", 1'b0, tx_valid);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk("rsp_ready", 1'b1, rsp_ready);
		// Ordinary requests, each answered once
		foreach (rows[n]) begin
			host_u.send(mk_req(rows[n]), 1'b0);
			wait_req();
			chk_req(rows[n]);
			send_rsp(ST_OK, (rows[n].vlen == 0) ? 2'h2 : 2'h0);
			expect_frame(rsp_body(rows[n], ST_OK,
				(rows[n].vlen == 0) ? 2'h2 : 2'h0));
		end
		// Zero identifier: result taken, nothing sent
		r = rows[0];
		r.id = 8'h00;
		host_u.send(mk_req(r), 1'b0);
		wait_req();
		send_rsp(ST_OK, 2'h2);
		repeat (30) @(negedge clk_sys);
		chk("silent", 0, host_u.rx_q.size());
		chk("rsp_ready", 1'b1, rsp_ready);
		// Bad checksum dropped, good frame right behind it accepted
		host_u.send(mk_req(rows[2]), 1'b1);
		wait_req();
		chk("csum_err", 1'b1, csum_err);
		chk("req_valid", 1'b0, req_valid);
		host_u.send(mk_req(rows[2]), 1'b0);
		wait_req();
		chk_req(rows[2]);
		// Several answers to one request, every status, slow host
		slow = 1'b1;
		for (int st = 0; st < 4; st++) begin
			b = rsp_body(rows[2], 8'(st), 2'(st));
			send_rsp(8'(st), 2'(st));
			expect_frame(b);
		end
		// Radio packets: option bits, then the two drop conditions
		for (int k = 0; k < 6; k++) begin
			out_opt = (k == 4) ? 8'h01 : OUT_LEGACY;
			rf_short = (k == 5) ? 16'h1234 : SHORT_NONE;
			{rf_all, rf_bc} = 2'(k);
			rf_len = 8'(k + 1);
			rf_valid = 1'b1;
			i = 0;
			while (rf_take !== 1'b1 && i < 50) begin
				@(negedge clk_sys);
				i++;
			end
			rf_valid = 1'b0;
			chk("rf_take", 1'b1, rf_take);
			if (k < 4) begin
				b = {T_RX64};
				for (int j = 7; j >= 0; j--)
					b.push_back(rf_addr[8*j+:8]);
				b.push_back(rf_dbm);
				b.push_back({5'h00, rf_all, rf_bc, 1'b0});
				for (int j = 0; j <= k; j++)
					b.push_back(8'hA0 + 8'(j));
				expect_frame(b);
			end else begin
				repeat (30) @(negedge clk_sys);
				chk("rf_drop", 0, host_u.rx_q.size());
			end
		end
		finish_test();
	end
endmodule // afr_frame_engine_tb
